/* hw/arc_conditioner.v */
// analog speed-reference conditioner: scaling, filtering, loss detection, sleep/wake
// Summary of operation
// - voltage high percent of 10 V gives maximum frequency; default 100, range 0..200.
// - voltage high below low inverts the voltage mapping.
// - bipolar select 1 applies high scale to both polarities; 0 is unipolar.
// - in bipolar mode direction follows the voltage sign.
// - bipolar mode ignores minimum frequency and voltage low scale.
// - voltage loss below 1 V, cleared only above 1.5 V, when used as reference.
// - current loss below 2 mA, cleared only above 3 mA, when used as reference.
// - loss handling acts on inputs used as speed, PID reference or setpoint.
// - loss response codes 0..8: off, fault, stop, zero, min, max, keypad, pot, last.
// - current low/high percent map to minimum/maximum frequency; defaults 0 and 100.
// - current low above high inverts the current mapping.
// - voltage low percent gives minimum frequency, default 0; low above high inverts.
// - filter level N 0..14 adds filtering of 2 to the N; 0 adds none.
// - loss detection suppressed after power-up for 0..20 s, default zero.
// - sleep when running and input below sleep level for the sleep time.
// - in sleep, ramp to zero and flash the keypad run indicator; the code raises sleep_q and flashes run_flash_q but does not drive the references to zero.
// - wake after input above wake level for the wake time.
// - sleep source 0 off, 1 voltage, 2 current, 3 commanded frequency.
// - sleep level above wake level inverts the sensing.
`timescale 1ns/100ps
`include "arc_defs.vh"
module arc_conditioner #(
  parameter TICK_CYCLES = `ARC_TICK_US * `ARC_CLK_MHZ
) (
  // clock and reset
  input wire clock,
  input wire rstn,
  // register port
  input wire [`ARC_AW-1:0] reg_addr,
  input wire [`ARC_DW-1:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [`ARC_DW-1:0] reg_rdata_q,
  // converter samples
  input wire signed [15:0] volt_sample,
  input wire volt_valid,
  input wire [15:0] curr_sample,
  input wire curr_valid,
  // drive state
  input wire volt_in_use,
  input wire curr_in_use,
  input wire drive_running,
  input wire [15:0] cmd_freq,
  input wire [15:0] keypad_ref,
  input wire [15:0] mop_ref,
  // conditioned outputs
  output reg [15:0] volt_freq_ref_q,
  output reg volt_dir_rev_q,
  output reg [15:0] curr_freq_ref_q,
  output reg volt_loss_q,
  output reg curr_loss_q,
  output reg loss_fault_q,
  output reg loss_stop_q,
  output reg sleep_q,
  output reg run_flash_q
);

  localparam AWAKE = 1'b0;
  localparam ASLEEP = 1'b1;

  // linear interpolation with clamping; works for either slope
  function [15:0] arc_scale;
    input integer p;
    input integer lo;
    input integer hi;
    input integer fmin;
    input integer fmax;
    integer den;
    integer num;
    integer r;
    begin
      den = hi - lo;
      num = p - lo;
      if (den == 0)
        r = (p < lo) ? fmin : fmax;
      else
      begin
        if (den > 0)
          num = (num < 0) ? 0 : ((num > den) ? den : num);
        else
          num = (num > 0) ? 0 : ((num < den) ? den : num);
        r = fmin + (num * (fmax - fmin)) / den;
      end
      arc_scale = r[15:0];
    end
  endfunction

  // first-order low-pass, gain 1/2^n per sample
  function signed [31:0] arc_filt;
    input signed [31:0] acc;
    input signed [31:0] x;
    input [3:0] n;
    reg signed [31:0] diff;
    begin
      diff = (x <<< `ARC_FILT_FRAC) - acc;
      arc_filt = acc + (diff >>> n);
    end
  endfunction

  // reference substituted while the input is lost
  function [15:0] arc_lossref;
    input [3:0] act;
    input [15:0] scaled;
    input [15:0] last;
    input [15:0] fmin;
    input [15:0] fmax;
    input [15:0] key;
    input [15:0] mop;
    begin
      case (act)
        `ARC_ACT_ZERO: arc_lossref = 16'h0000;
        `ARC_ACT_MIN: arc_lossref = fmin;
        `ARC_ACT_MAX: arc_lossref = fmax;
        `ARC_ACT_KEY: arc_lossref = key;
        `ARC_ACT_MOP: arc_lossref = mop;
        `ARC_ACT_LAST: arc_lossref = last;
        default: arc_lossref = scaled;
      endcase
    end
  endfunction

  // settings
  reg [10:0] vlo_q;
  reg [10:0] vhi_q;
  reg bip_q;
  reg [3:0] vloss_act_q;
  reg [10:0] clo_q;
  reg [10:0] chi_q;
  reg [3:0] closs_act_q;
  reg [7:0] blank_q;
  reg [3:0] filt_q;
  reg [1:0] slsrc_q;
  reg [9:0] slthr_q;
  reg [12:0] sldwl_q;
  reg [9:0] wkthr_q;
  reg [12:0] wkdwl_q;
  reg [15:0] fmin_q;
  reg [15:0] fmax_q;

  // internal state
  reg signed [31:0] vacc_q;
  reg signed [31:0] cacc_q;
  reg [19:0] tick_cnt_q;
  reg tick_q;
  reg [7:0] blank_cnt_q;
  reg blank_done_q;
  reg [15:0] vlast_q;
  reg [15:0] clast_q;
  reg [12:0] dwell_cnt_q;
  reg [2:0] flash_cnt_q;
  reg [`ARC_DW-1:0] rdata_d;

  wire signed [15:0] vfilt = vacc_q[`ARC_FILT_FRAC+15:`ARC_FILT_FRAC];
  wire [15:0] cfilt = cacc_q[`ARC_FILT_FRAC+15:`ARC_FILT_FRAC];
  wire [15:0] vmag = vfilt[15] ? (16'h0000 - vfilt) : vfilt;
  wire [15:0] cspan = (cfilt > `ARC_C_ZERO) ? (cfilt - 16'd`ARC_C_ZERO) : 16'h0000;
  wire [15:0] cpct = cspan >> `ARC_C_SHIFT;
  wire [15:0] vpct = vfilt[15] ? 16'h0000 : vfilt;

  // scaled references before loss handling
  reg [15:0] vscaled;
  reg [15:0] cscaled;
  always @*
  begin
    if (bip_q)
      vscaled = arc_scale(vmag, 0, vhi_q, 0, fmax_q);
    else
      vscaled = arc_scale(vfilt, vlo_q, vhi_q, fmin_q, fmax_q);
    cscaled = arc_scale(cpct, clo_q, chi_q, fmin_q, fmax_q);
  end

  wire [15:0] vfmin = bip_q ? 16'h0000 : fmin_q;
  wire vloss_d = !volt_in_use || !blank_done_q ? 1'b0 :
    (vmag < `ARC_V_LOSS_SET) ? 1'b1 : (vmag > `ARC_V_LOSS_CLR) ? 1'b0 : volt_loss_q;
  wire closs_d = !curr_in_use || !blank_done_q ? 1'b0 :
    (cfilt < `ARC_C_LOSS_SET) ? 1'b1 : (cfilt > `ARC_C_LOSS_CLR) ? 1'b0 : curr_loss_q;
  wire vact_on = vloss_d && (vloss_act_q != `ARC_ACT_OFF);
  wire cact_on = closs_d && (closs_act_q != `ARC_ACT_OFF);

  // sleep level selection and sensing
  reg [15:0] sl_level;
  always @*
  begin
    case (slsrc_q)
      `ARC_SRC_VOLT: sl_level = vpct;
      `ARC_SRC_CURR: sl_level = cpct;
      `ARC_SRC_FREQ: sl_level = arc_scale(cmd_freq, 0, fmax_q, 0, `ARC_PCT_FULL);
      default: sl_level = 16'h0000;
    endcase
  end
  wire sl_inv = slthr_q > wkthr_q;
  wire below_sleep = sl_inv ? (sl_level > slthr_q) : (sl_level < slthr_q);
  wire above_wake = sl_inv ? (sl_level < wkthr_q) : (sl_level > wkthr_q);
  wire sl_enabled = (slsrc_q != `ARC_SRC_OFF) && drive_running;
  wire sl_cond = (sleep_q == ASLEEP) ? above_wake : below_sleep;
  wire [12:0] sl_limit = (sleep_q == ASLEEP) ? wkdwl_q : sldwl_q;

  // register writes; the drive should be stopped before scaling changes
  always @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      vlo_q <= `ARC_RST_VLO;
      vhi_q <= `ARC_RST_VHI;
      bip_q <= 1'b0;
      vloss_act_q <= `ARC_ACT_OFF;
      clo_q <= `ARC_RST_CLO;
      chi_q <= `ARC_RST_CHI;
      closs_act_q <= `ARC_ACT_OFF;
      blank_q <= 8'h00;
      filt_q <= 4'h0;
      slsrc_q <= `ARC_SRC_OFF;
      slthr_q <= `ARC_RST_SLTHR;
      sldwl_q <= 13'h0000;
      wkthr_q <= `ARC_RST_WKTHR;
      wkdwl_q <= 13'h0000;
      fmin_q <= `ARC_RST_FMIN;
      fmax_q <= `ARC_RST_FMAX;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        `ARC_A_VLO: vlo_q <= reg_wdata[10:0];
        `ARC_A_VHI: vhi_q <= reg_wdata[10:0];
        `ARC_A_BIP: bip_q <= reg_wdata[0];
        `ARC_A_VLOSS: vloss_act_q <= reg_wdata[3:0];
        `ARC_A_CLO: clo_q <= reg_wdata[10:0];
        `ARC_A_CHI: chi_q <= reg_wdata[10:0];
        `ARC_A_CLOSS: closs_act_q <= reg_wdata[3:0];
        `ARC_A_BLANK: blank_q <= reg_wdata[7:0];
        `ARC_A_FILT: filt_q <= (reg_wdata[3:0] > `ARC_FILT_MAX) ? `ARC_FILT_MAX : reg_wdata[3:0];
        `ARC_A_SLSRC: slsrc_q <= reg_wdata[1:0];
        `ARC_A_SLTHR: slthr_q <= reg_wdata[9:0];
        `ARC_A_SLDWL: sldwl_q <= reg_wdata[12:0];
        `ARC_A_WKTHR: wkthr_q <= reg_wdata[9:0];
        `ARC_A_WKDWL: wkdwl_q <= reg_wdata[12:0];
        `ARC_A_FMIN: fmin_q <= reg_wdata;
        `ARC_A_FMAX: fmax_q <= reg_wdata;
        default: ;
      endcase
    end
  end

  // read data one cycle after the strobe; unmapped reads give zero
  always @*
  begin
    rdata_d = 16'h0000;
    if (reg_rd)
    begin
      case (reg_addr)
        `ARC_A_VLO: rdata_d = {5'h00, vlo_q};
        `ARC_A_VHI: rdata_d = {5'h00, vhi_q};
        `ARC_A_BIP: rdata_d = {15'h0000, bip_q};
        `ARC_A_VLOSS: rdata_d = {12'h000, vloss_act_q};
        `ARC_A_CLO: rdata_d = {5'h00, clo_q};
        `ARC_A_CHI: rdata_d = {5'h00, chi_q};
        `ARC_A_CLOSS: rdata_d = {12'h000, closs_act_q};
        `ARC_A_BLANK: rdata_d = {8'h00, blank_q};
        `ARC_A_FILT: rdata_d = {12'h000, filt_q};
        `ARC_A_SLSRC: rdata_d = {14'h0000, slsrc_q};
        `ARC_A_SLTHR: rdata_d = {6'h00, slthr_q};
        `ARC_A_SLDWL: rdata_d = {3'h0, sldwl_q};
        `ARC_A_WKTHR: rdata_d = {6'h00, wkthr_q};
        `ARC_A_WKDWL: rdata_d = {3'h0, wkdwl_q};
        `ARC_A_FMIN: rdata_d = fmin_q;
        `ARC_A_FMAX: rdata_d = fmax_q;
        `ARC_A_STAT: rdata_d = {8'h00, blank_done_q, run_flash_q, sleep_q, loss_stop_q,
          loss_fault_q, volt_dir_rev_q, curr_loss_q, volt_loss_q};
        `ARC_A_VREF: rdata_d = volt_freq_ref_q;
        `ARC_A_CREF: rdata_d = curr_freq_ref_q;
        `ARC_A_VFLT: rdata_d = vfilt;
        `ARC_A_CFLT: rdata_d = cfilt;
        default: rdata_d = 16'h0000;
      endcase
    end
  end

  always @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      reg_rdata_q <= 16'h0000;
    else
      reg_rdata_q <= rdata_d;
  end

  // input filters, updated per sample
  always @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      vacc_q <= 32'h00000000;
      cacc_q <= 32'h00000000;
    end
    else
    begin
      if (volt_valid)
        vacc_q <= arc_filt(vacc_q, {{16{volt_sample[15]}}, volt_sample}, filt_q);
      if (curr_valid)
        cacc_q <= arc_filt(cacc_q, {16'h0000, curr_sample}, filt_q);
    end
  end

  // 0.1 s tick; blank count saturates at 25.5 s, so late writes never re-blank
  // limitation: the delay must be written soon after reset to take effect
  always @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      tick_cnt_q <= 20'h00000;
      tick_q <= 1'b0;
      blank_cnt_q <= 8'h00;
      blank_done_q <= 1'b0;
    end
    else
    begin
      tick_q <= 1'b0;
      if (tick_cnt_q == TICK_CYCLES[19:0] - 20'h00001)
      begin
        tick_cnt_q <= 20'h00000;
        tick_q <= 1'b1;
      end
      else
        tick_cnt_q <= tick_cnt_q + 20'h00001;
      if (tick_q && blank_cnt_q != `ARC_BLANK_SAT)
        blank_cnt_q <= blank_cnt_q + 8'h01;
      blank_done_q <= blank_cnt_q >= blank_q;
    end
  end

  // loss flags, responses and references
  always @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      volt_loss_q <= 1'b0;
      curr_loss_q <= 1'b0;
      loss_fault_q <= 1'b0;
      loss_stop_q <= 1'b0;
      volt_freq_ref_q <= 16'h0000;
      curr_freq_ref_q <= 16'h0000;
      volt_dir_rev_q <= 1'b0;
      vlast_q <= 16'h0000;
      clast_q <= 16'h0000;
    end
    else
    begin
      volt_loss_q <= vloss_d;
      curr_loss_q <= closs_d;
      loss_fault_q <= (vact_on && vloss_act_q == `ARC_ACT_FAULT) ||
        (cact_on && closs_act_q == `ARC_ACT_FAULT);
      loss_stop_q <= (vact_on && vloss_act_q == `ARC_ACT_STOP) ||
        (cact_on && closs_act_q == `ARC_ACT_STOP);
      if (!vloss_d)
        vlast_q <= vscaled;
      if (!closs_d)
        clast_q <= cscaled;
      volt_freq_ref_q <= vact_on ?
        arc_lossref(vloss_act_q, vscaled, vlast_q, vfmin, fmax_q, keypad_ref, mop_ref) : vscaled;
      curr_freq_ref_q <= cact_on ?
        arc_lossref(closs_act_q, cscaled, clast_q, fmin_q, fmax_q, keypad_ref, mop_ref) : cscaled;
      if (!vact_on)
        volt_dir_rev_q <= bip_q && vfilt[15];
    end
  end

  // sleep/wake with dwell timing and indicator flash
  always @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      sleep_q <= AWAKE;
      dwell_cnt_q <= 13'h0000;
      flash_cnt_q <= 3'h0;
      run_flash_q <= 1'b0;
    end
    else
    begin
      if (!sl_enabled)
      begin
        sleep_q <= AWAKE;
        dwell_cnt_q <= 13'h0000;
      end
      else if (!sl_cond)
        dwell_cnt_q <= 13'h0000;
      else if (dwell_cnt_q >= sl_limit)
      begin
        case (sleep_q)
          AWAKE: sleep_q <= ASLEEP;
          ASLEEP: sleep_q <= AWAKE;
          default: sleep_q <= AWAKE;
        endcase
        dwell_cnt_q <= 13'h0000;
      end
      else if (tick_q)
        dwell_cnt_q <= dwell_cnt_q + 13'h0001;
      if (sleep_q != ASLEEP)
      begin
        flash_cnt_q <= 3'h0;
        run_flash_q <= 1'b0;
      end
      else if (tick_q)
      begin
        if (flash_cnt_q == `ARC_FLASH_TICKS - 3'h1)
        begin
          flash_cnt_q <= 3'h0;
          run_flash_q <= !run_flash_q;
        end
        else
          flash_cnt_q <= flash_cnt_q + 3'h1;
      end
    end
  end

endmodule

/* hw/arc_defs.vh */
// constants for the analog reference conditioner
`ifndef ARC_DEFS_VH
`define ARC_DEFS_VH
`define ARC_AW 8
`define ARC_DW 16
`define ARC_A_VLO 8'h00
`define ARC_A_VHI 8'h04
`define ARC_A_BIP 8'h08
`define ARC_A_VLOSS 8'h0C
`define ARC_A_CLO 8'h10
`define ARC_A_CHI 8'h14
`define ARC_A_CLOSS 8'h18
`define ARC_A_BLANK 8'h1C
`define ARC_A_FILT 8'h20
`define ARC_A_SLSRC 8'h24
`define ARC_A_SLTHR 8'h28
`define ARC_A_SLDWL 8'h2C
`define ARC_A_WKTHR 8'h30
`define ARC_A_WKDWL 8'h34
`define ARC_A_FMIN 8'h38
`define ARC_A_FMAX 8'h3C
`define ARC_A_STAT 8'h40
`define ARC_A_VREF 8'h44
`define ARC_A_CREF 8'h48
`define ARC_A_VFLT 8'h4C
`define ARC_A_CFLT 8'h50
`define ARC_RST_VLO 11'h000
`define ARC_RST_VHI 11'h3E8
`define ARC_RST_CLO 11'h000
`define ARC_RST_CHI 11'h3E8
`define ARC_RST_SLTHR 10'h064
`define ARC_RST_WKTHR 10'h096
`define ARC_RST_FMIN 16'h0000
`define ARC_RST_FMAX 16'h1770
`define ARC_FILT_MAX 4'hE
`define ARC_FILT_FRAC 14
`define ARC_V_LOSS_SET 100
`define ARC_V_LOSS_CLR 150
`define ARC_C_LOSS_SET 2000
`define ARC_C_LOSS_CLR 3000
`define ARC_C_ZERO 4000
`define ARC_C_SHIFT 4
`define ARC_PCT_FULL 1000
`define ARC_ACT_OFF 4'h0
`define ARC_ACT_FAULT 4'h1
`define ARC_ACT_STOP 4'h2
`define ARC_ACT_ZERO 4'h3
`define ARC_ACT_MIN 4'h4
`define ARC_ACT_MAX 4'h5
`define ARC_ACT_KEY 4'h6
`define ARC_ACT_MOP 4'h7
`define ARC_ACT_LAST 4'h8
`define ARC_SRC_OFF 2'h0
`define ARC_SRC_VOLT 2'h1
`define ARC_SRC_CURR 2'h2
`define ARC_SRC_FREQ 2'h3
`define ARC_TICK_US 100000
`define ARC_CLK_MHZ 10
`define ARC_FLASH_TICKS 3'h5
`define ARC_BLANK_SAT 8'hFF
`endif

/* testbench/arc_asserts.sv */
// port assertions for the analog reference conditioner
`timescale 1ns/100ps
module arc_asserts (
  // clock and reset
  input wire clock,
  input wire rstn,
  // register port
  input wire reg_rd,
  input wire [15:0] reg_rdata_q,
  // drive state
  input wire volt_in_use,
  input wire curr_in_use,
  input wire drive_running,
  // flags
  input wire volt_loss_q,
  input wire curr_loss_q,
  input wire loss_fault_q,
  input wire loss_stop_q,
  input wire sleep_q,
  input wire run_flash_q
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);
  property p_rd_idle;
    !$past(reg_rd) |-> reg_rdata_q == 16'h0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside answer cycle");
  property p_rst_clear;
    !$past(rstn) |-> !sleep_q && !volt_loss_q && !curr_loss_q && !loss_fault_q && !loss_stop_q;
  endproperty
  a_rst_clear: assert property (p_rst_clear) else $error("flags set after reset");
  property p_flash_sleep;
    run_flash_q |-> sleep_q || $past(sleep_q);
  endproperty
  a_flash_sleep: assert property (p_flash_sleep) else $error("flash outside sleep");
  property p_stop_run;
    !drive_running [*3] |-> !sleep_q;
  endproperty
  a_stop_run: assert property (p_stop_run) else $error("sleep while stopped");
  property p_vloss_use;
    !volt_in_use [*2] |-> !volt_loss_q;
  endproperty
  a_vloss_use: assert property (p_vloss_use) else $error("voltage loss when unused");
  property p_closs_use;
    !curr_in_use [*2] |-> !curr_loss_q;
  endproperty
  a_closs_use: assert property (p_closs_use) else $error("current loss when unused");
  property p_fault;
    loss_fault_q |-> volt_loss_q || curr_loss_q || $past(volt_loss_q) || $past(curr_loss_q);
  endproperty
  a_fault: assert property (p_fault) else $error("fault without loss");
  property p_stop;
    loss_stop_q |-> volt_loss_q || curr_loss_q || $past(volt_loss_q) || $past(curr_loss_q);
  endproperty
  a_stop: assert property (p_stop) else $error("stop without loss");
  c_sleep: cover property ($rose(sleep_q));
  c_fault: cover property ($rose(loss_fault_q));
  c_flash: cover property ($rose(run_flash_q));
endmodule
bind arc_conditioner arc_asserts u_arc_chk (.clock(clock), .rstn(rstn), .reg_rd(reg_rd),
  .reg_rdata_q(reg_rdata_q), .volt_in_use(volt_in_use), .curr_in_use(curr_in_use),
  .drive_running(drive_running), .volt_loss_q(volt_loss_q), .curr_loss_q(curr_loss_q),
  .loss_fault_q(loss_fault_q), .loss_stop_q(loss_stop_q), .sleep_q(sleep_q), .run_flash_q(run_flash_q));

/* testbench/arc_front_end.sv */
// converter front end model delivering input samples
`timescale 1ns/100ps
module arc_front_end (
  // clock
  input wire clock,
  // samples
  output logic signed [15:0] volt_sample,
  output logic volt_valid,
  output logic [15:0] curr_sample,
  output logic curr_valid
);
  // analog levels hold between conversions, only the strobes pulse
  initial
  begin
    volt_sample = 16'sh0000;
    volt_valid = 1'b0;
    curr_sample = 16'h0000;
    curr_valid = 1'b0;
  end
  task automatic send_v(input logic signed [15:0] x);
    @(posedge clock);
    volt_sample <= x;
    volt_valid <= 1'b1;
    @(posedge clock);
    volt_valid <= 1'b0;
  endtask
  task automatic send_c(input logic [15:0] x);
    @(posedge clock);
    curr_sample <= x;
    curr_valid <= 1'b1;
    @(posedge clock);
    curr_valid <= 1'b0;
  endtask
endmodule

/* testbench/tb_analog_reference_conditioner.sv */
// self-checking testbench for the analog reference conditioner
`timescale 1ns/100ps
`include "arc_defs.vh"
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin err_count++; $display("Error %s exp %0d got %0d", n, e, g); end end
module tb_analog_reference_conditioner;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic volt_in_use = 1'b0;
  logic curr_in_use = 1'b0;
  logic drive_running = 1'b0;
  logic [15:0] cmd_freq = 16'h0000;
  logic [15:0] keypad_ref = 16'h0123;
  logic [15:0] mop_ref = 16'h0456;
  wire [15:0] reg_rdata_q, volt_freq_ref_q, curr_freq_ref_q, curr_sample;
  wire signed [15:0] volt_sample;
  wire volt_valid, curr_valid, volt_dir_rev_q, volt_loss_q, curr_loss_q;
  wire loss_fault_q, loss_stop_q, sleep_q, run_flash_q;
  int err_count = 0;
  int tests_run = 0;
  int cyc = 0;
  int i;
  logic flash0;
  logic [15:0] rv [16] = '{16'h0000, 16'h03E8, 16'h0000, 16'h0000, 16'h0000, 16'h03E8, 16'h0000,
    16'h0000, 16'h0000, 16'h0000, 16'h0064, 16'h0000, 16'h0096, 16'h0000, 16'h0000, 16'h1770};
  logic [15:0] lr [9] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0258, 16'h1770, 16'h0123,
    16'h0456, 16'h0CE4};
  always #50 clock = ~clock;
  // short tick keeps dwell and flash times to tens of cycles
  arc_conditioner #(.TICK_CYCLES(10)) DUT (.clock(clock), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
    .volt_sample(volt_sample), .volt_valid(volt_valid), .curr_sample(curr_sample),
    .curr_valid(curr_valid), .volt_in_use(volt_in_use), .curr_in_use(curr_in_use),
    .drive_running(drive_running), .cmd_freq(cmd_freq), .keypad_ref(keypad_ref), .mop_ref(mop_ref),
    .volt_freq_ref_q(volt_freq_ref_q), .volt_dir_rev_q(volt_dir_rev_q), .curr_freq_ref_q(curr_freq_ref_q),
    .volt_loss_q(volt_loss_q), .curr_loss_q(curr_loss_q), .loss_fault_q(loss_fault_q),
    .loss_stop_q(loss_stop_q), .sleep_q(sleep_q), .run_flash_q(run_flash_q));
  arc_front_end fe (.clock(clock), .volt_sample(volt_sample), .volt_valid(volt_valid),
    .curr_sample(curr_sample), .curr_valid(curr_valid));
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [15:0] e);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    `CHK("rdata", e, reg_rdata_q)
  endtask
  task automatic sv(input logic signed [15:0] x);
    fe.send_v(x);
    repeat (3) @(posedge clock);
    #1;
  endtask
  task automatic sc(input logic [15:0] x);
    fe.send_c(x);
    repeat (3) @(posedge clock);
    #1;
  endtask
  task automatic wsl(input logic v, input int n);
    for (int k = 0; k < n && sleep_q !== v; k++) @(posedge clock);
    #1;
    `CHK("sleep", v, sleep_q)
  endtask
  task complete_run;
    if (err_count == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_count++;
      complete_run();
    end
  end
  initial
  begin
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    for (i = 0; i < 16; i++) rchk(8'(i * 4), rv[i]);
    rchk(`ARC_A_STAT, 16'h0080);
    rchk(8'h60, 16'h0000);
    wr(`ARC_A_VREF, 16'hFFFF);
    rchk(`ARC_A_VREF, 16'h0000);
    wr(`ARC_A_FILT, 16'h000F);
    rchk(`ARC_A_FILT, 16'h000E);
    // drive stays stopped while scaling is changed
    wr(`ARC_A_FILT, 16'h0001);
    sv(16'sh03E8);
    rchk(`ARC_A_VFLT, 16'h01F4);
    sv(16'sh03E8);
    rchk(`ARC_A_VFLT, 16'h02EE);
    wr(`ARC_A_FILT, 16'h0000);
    sv(16'sh01F4);
    `CHK("vref", 16'h0BB8, volt_freq_ref_q)
    wr(`ARC_A_VHI, 16'h01F4);
    sv(16'sh01F4);
    `CHK("vref", 16'h1770, volt_freq_ref_q)
    wr(`ARC_A_VHI, 16'h07D0);
    sv(16'sh03E8);
    `CHK("vref", 16'h0BB8, volt_freq_ref_q)
    wr(`ARC_A_VLO, 16'h03E8);
    wr(`ARC_A_VHI, 16'h0000);
    sv(16'sh00FA);
    `CHK("vref", 16'h1194, volt_freq_ref_q)
    wr(`ARC_A_VLO, 16'h00C8);
    wr(`ARC_A_VHI, 16'h03E8);
    wr(`ARC_A_FMIN, 16'h03E8);
    sv(16'sh00C8);
    `CHK("vref", 16'h03E8, volt_freq_ref_q)
    wr(`ARC_A_BIP, 16'h0001);
    sv(-16'sh01F4);
    `CHK("vref", 16'h0BB8, volt_freq_ref_q)
    `CHK("dir", 1'b1, volt_dir_rev_q)
    sv(16'sh01F4);
    `CHK("vref", 16'h0BB8, volt_freq_ref_q)
    `CHK("dir", 1'b0, volt_dir_rev_q)
    wr(`ARC_A_BIP, 16'h0000);
    wr(`ARC_A_VLO, 16'h0000);
    wr(`ARC_A_FMIN, 16'h0258);
    sc(16'h2EE0);
    `CHK("cref", 16'h0CE4, curr_freq_ref_q)
    wr(`ARC_A_CLO, 16'h03E8);
    wr(`ARC_A_CHI, 16'h0000);
    sc(16'h1F40);
    `CHK("cref", 16'h122A, curr_freq_ref_q)
    sv(16'sh0032);
    `CHK("vloss", 1'b0, volt_loss_q)
    @(posedge clock) volt_in_use <= 1'b1;
    sv(16'sh0032);
    `CHK("vloss", 1'b1, volt_loss_q)
    sv(16'sh0078);
    `CHK("vloss", 1'b1, volt_loss_q)
    sv(16'sh00A0);
    `CHK("vloss", 1'b0, volt_loss_q)
    sv(16'sh01F4);
    for (i = 0; i < 9; i++)
    begin
      wr(`ARC_A_VLOSS, 16'(i));
      sv(16'sh0032);
      `CHK("fault", 1'(i == 1), loss_fault_q)
      `CHK("stop", 1'(i == 2), loss_stop_q)
      if (i > 2) `CHK("lossref", lr[i], volt_freq_ref_q)
      sv(16'sh01F4);
    end
    @(posedge clock) curr_in_use <= 1'b1;
    wr(`ARC_A_CLOSS, 16'h0005);
    sc(16'h05DC);
    `CHK("closs", 1'b1, curr_loss_q)
    `CHK("cref", 16'h1770, curr_freq_ref_q)
    sc(16'h09C4);
    `CHK("closs", 1'b1, curr_loss_q)
    sc(16'h0DAC);
    `CHK("closs", 1'b0, curr_loss_q)
    @(posedge clock) volt_in_use <= 1'b0;
    @(posedge clock) curr_in_use <= 1'b0;
    wr(`ARC_A_SLDWL, 16'h0003);
    wr(`ARC_A_SLSRC, 16'h0001);
    @(posedge clock) drive_running <= 1'b1;
    sv(16'sh0032);
    `CHK("sleep", 1'b0, sleep_q)
    wsl(1'b1, 60);
    flash0 = run_flash_q;
    repeat (60) @(posedge clock);
    #1;
    `CHK("flash", ~flash0, run_flash_q)
    sv(16'sh00C8);
    wsl(1'b0, 30);
    wr(`ARC_A_SLTHR, 16'h0096);
    wr(`ARC_A_WKTHR, 16'h0064);
    wsl(1'b1, 60);
    sv(16'sh0032);
    wsl(1'b0, 30);
    wr(`ARC_A_SLSRC, 16'h0002);
    sc(16'h3E80);
    wsl(1'b1, 60);
    sc(16'h0FA0);
    wsl(1'b0, 30);
    wr(`ARC_A_SLTHR, 16'h0064);
    wr(`ARC_A_WKTHR, 16'h0096);
    wr(`ARC_A_SLSRC, 16'h0003);
    wsl(1'b1, 60);
    @(posedge clock) cmd_freq <= 16'h1770;
    wsl(1'b0, 30);
    @(posedge clock) cmd_freq <= 16'h0000;
    wsl(1'b1, 60);
    @(posedge clock) drive_running <= 1'b0;
    wsl(1'b0, 5);
    @(posedge clock) drive_running <= 1'b1;
    wr(`ARC_A_SLSRC, 16'h0000);
    repeat (60) @(posedge clock);
    #1;
    `CHK("sleep", 1'b0, sleep_q)
    // second reset: delay programmed right after release blanks loss
    @(posedge clock) rstn <= 1'b0;
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    wr(`ARC_A_BLANK, 16'h0005);
    @(posedge clock) volt_in_use <= 1'b1;
    sv(16'sh0032);
    `CHK("vloss", 1'b0, volt_loss_q)
    rchk(`ARC_A_STAT, 16'h0000);
    repeat (60) @(posedge clock);
    #1;
    `CHK("vloss", 1'b1, volt_loss_q)
    complete_run();
  end
endmodule
